// ===== rtl/bscan_ctrl_pkg.sv
// Package with instruction codes, pin-source encodings and constants of the test-port instruction control.
package bscan_ctrl_pkg;

  // ==========================================================================
  // Instruction register
  // ==========================================================================
  localparam int unsigned IR_W        = 3;
  localparam logic [2:0]  IR_EXTEST   = 3'h0;
  localparam logic [2:0]  IR_IDCODE   = 3'h1;
  localparam logic [2:0]  IR_SAMPLE_Z = 3'h2;
  localparam logic [2:0]  IR_SAMPLE   = 3'h4;
  localparam logic [2:0]  IR_BYPASS   = 3'h7;
  localparam logic [2:0]  IR_RESET    = IR_IDCODE;
  localparam int unsigned IR_HIGH_POS = 2;
  localparam int unsigned IR_MID_POS  = 1;
  localparam int unsigned IR_LOW_POS  = 0;

  // ==========================================================================
  // Data registers
  // ==========================================================================
  localparam int unsigned ID_W        = 32;
  localparam int unsigned CTRL_CELL   = 48;
  localparam logic        CTRL_RESET  = 1'b0;
  localparam logic        BYP_RESET   = 1'b0;

  // ==========================================================================
  // Pin source and crossing
  // ==========================================================================
  localparam logic [1:0]  SRC_CORE    = 2'h0;
  localparam logic [1:0]  SRC_UPDATE  = 2'h1;
  localparam logic [1:0]  SRC_HIZ     = 2'h2;
  localparam int unsigned DQ_W_DEF    = 18;

endpackage

// ===== rtl/boundary_scan_instruction_ctrl.sv
// Test-port instruction decode, shadow instruction, output-control cell and pin source selection.
`timescale 1ns/10ps

module boundary_scan_instruction_ctrl
  import bscan_ctrl_pkg::*;
#(
  parameter int unsigned      DQ_W     = DQ_W_DEF,
  // Identification value is arbitrary; bit 0 stays one as the test standard expects.
  parameter logic [ID_W-1:0]  ID_VALUE = 32'h1234_5679
) (
  input  wire logic            ref_clk_i,
  input  wire logic            srst_i,
  input  wire logic            tck_i,
  input  wire logic            tlr_i,
  input  wire logic            tdi_i,
  input  wire logic            capture_dr_i,
  input  wire logic            shift_ir_i,
  input  wire logic            update_ir_i,
  input  wire logic            shift_dr_i,
  input  wire logic            update_dr_i,
  input  wire logic            bsr_so_i,
  input  wire logic            ctrl_shift_i,
  input  wire logic            upd_echo_i,
  input  wire logic            upd_echo_n_i,
  input  wire logic [DQ_W-1:0] upd_dq_i,
  output logic                 tdo_o,
  output logic                 tdo_oe_o,
  output logic [IR_W-1:0]      instr_o,
  output logic                 instr_bit_high_o,
  output logic                 instr_bit_mid_o,
  output logic                 instr_bit_low_o,
  input  wire logic            core_echo_i,
  input  wire logic            core_echo_n_i,
  input  wire logic [DQ_W-1:0] core_dq_i,
  input  wire logic            core_dq_oe_i,
  input  wire logic            mem_read_i,
  output logic                 echo_clock_out_o,
  output logic                 echo_clock_out_n_o,
  output logic                 echo_oe_o,
  output logic [DQ_W-1:0]      dq_o,
  output logic                 dq_oe_o,
  output logic                 cap_echo_pad_o,
  output logic                 cap_dq_pad_o
);

  localparam int unsigned HOLD_W = IR_W + 3 + DQ_W;

  // ==========================================================================
  // Test clock domain: instruction, bypass, identification, control cell
  // ==========================================================================
  logic [IR_W-1:0]   ir_shift_ff;
  logic [IR_W-1:0]   ir_ff;
  logic              bypass_ff;
  logic [ID_W-1:0]   id_ff;
  logic              ctrl_ff;
  logic              tdo_ff;
  logic              tdo_oe_ff;
  logic [HOLD_W-1:0] hold_ff;
  logic              tog_ff;
  logic              tlr_q_ff;
  logic              ctrl_load;

  always_ff @(posedge tck_i) begin
    if (tlr_i) begin
      ir_shift_ff <= IR_RESET;
    end else if (shift_ir_i) begin
      ir_shift_ff <= {tdi_i, ir_shift_ff[IR_W-1:1]};
    end
  end

  // The shadow only moves in Update-IR or Test-Logic-Reset, so pins keep their source while a new code shifts in.
  always_ff @(posedge tck_i) begin
    if (tlr_i) begin
      ir_ff <= IR_RESET;
    end else if (update_ir_i) begin
      ir_ff <= ir_shift_ff;
    end
  end

  always_ff @(posedge tck_i) begin
    if (tlr_i) begin
      bypass_ff <= BYP_RESET;
    end else if (shift_dr_i && ir_ff == IR_BYPASS) begin
      bypass_ff <= tdi_i;
    end
  end

  always_ff @(posedge tck_i) begin
    if (tlr_i) begin
      id_ff <= ID_VALUE;
    end else if (capture_dr_i && ir_ff == IR_IDCODE) begin
      id_ff <= ID_VALUE;
    end else if (shift_dr_i && ir_ff == IR_IDCODE) begin
      id_ff <= {tdi_i, id_ff[ID_W-1:1]};
    end
  end

  assign ctrl_load = update_dr_i && (ir_ff == IR_EXTEST || ir_ff == IR_SAMPLE);

  // Cell CTRL_CELL of the chain lives outside; its shift stage arrives on ctrl_shift_i.
  always_ff @(posedge tck_i) begin
    if (tlr_i) begin
      ctrl_ff <= CTRL_RESET;
    end else if (ctrl_load) begin
      ctrl_ff <= ctrl_shift_i;
    end
  end

  always_ff @(posedge tck_i) begin
    if (tlr_i) begin
      tdo_ff    <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end else begin
      tdo_oe_ff <= shift_ir_i || shift_dr_i;
      if (shift_ir_i) begin
        tdo_ff <= ir_shift_ff[0];
      end else if (ir_ff == IR_BYPASS) begin
        tdo_ff <= bypass_ff;
      end else if (ir_ff == IR_IDCODE) begin
        tdo_ff <= id_ff[0];
      end else begin
        tdo_ff <= bsr_so_i;
      end
    end
  end

  // Hold register is loaded with the reset values in Test-Logic-Reset and rewritten with a toggle only at an update or as Test-Logic-Reset ends.
  // Leaving reset always toggles, so the memory side returns to identification whatever the toggle parity was.
  // Test-Logic-Reset must span two test clocks so that the memory side also sees the dip of the toggle.
  always_ff @(posedge tck_i) begin
    tlr_q_ff <= tlr_i;
    if (tlr_i) begin
      hold_ff <= {IR_RESET, CTRL_RESET, 1'b0, 1'b0, {DQ_W{1'b0}}};
      tog_ff  <= 1'b0;
    end else if (tlr_q_ff || update_ir_i || update_dr_i) begin
      hold_ff <= {(update_ir_i ? ir_shift_ff : ir_ff), (ctrl_load ? ctrl_shift_i : ctrl_ff),
                  upd_echo_i, upd_echo_n_i, upd_dq_i};
      tog_ff  <= ~tog_ff;
    end
  end

  assign tdo_o            = tdo_ff;
  assign tdo_oe_o         = tdo_oe_ff;
  assign instr_o          = ir_ff;
  assign instr_bit_high_o = ir_ff[IR_HIGH_POS];
  assign instr_bit_mid_o  = ir_ff[IR_MID_POS];
  assign instr_bit_low_o  = ir_ff[IR_LOW_POS];

  // ==========================================================================
  // Memory clock domain: toggle crossing and pin control
  // ==========================================================================
  logic            tog_s1_ff;
  logic            tog_s2_ff;
  logic            tog_s3_ff;
  logic [IR_W-1:0] ir_r_ff;
  logic            ctrl_r_ff;
  logic            upd_echo_r_ff;
  logic            upd_echo_n_r_ff;
  logic [DQ_W-1:0] upd_dq_r_ff;

  // The memory clocks are unrelated to the test clock, so settings cross as one event.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      tog_s1_ff <= 1'b0;
      tog_s2_ff <= 1'b0;
      tog_s3_ff <= 1'b0;
    end else begin
      tog_s1_ff <= tog_ff;
      tog_s2_ff <= tog_s1_ff;
      tog_s3_ff <= tog_s2_ff;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      ir_r_ff         <= IR_RESET;
      ctrl_r_ff       <= CTRL_RESET;
      upd_echo_r_ff   <= 1'b0;
      upd_echo_n_r_ff <= 1'b0;
      upd_dq_r_ff     <= {DQ_W{1'b0}};
    end else if (tog_s2_ff ^ tog_s3_ff) begin
      {ir_r_ff, ctrl_r_ff, upd_echo_r_ff, upd_echo_n_r_ff, upd_dq_r_ff} <= hold_ff;
    end
  end

  function automatic logic [1:0] echo_src(input logic [IR_W-1:0] ir);
    case (ir)
      IR_EXTEST:   echo_src = SRC_UPDATE;
      IR_SAMPLE_Z: echo_src = SRC_HIZ;
      // Codes the controller never loads fall back to the core path.
      default:     echo_src = SRC_CORE;
    endcase
  endfunction

  function automatic logic [1:0] dq_src(input logic [IR_W-1:0] ir, input logic ctrl);
    case (ir)
      IR_EXTEST:   dq_src = ctrl ? SRC_UPDATE : SRC_HIZ;
      IR_SAMPLE_Z: dq_src = SRC_HIZ;
      default:     dq_src = SRC_CORE;
    endcase
  endfunction

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      echo_clock_out_o   <= 1'b0;
      echo_clock_out_n_o <= 1'b0;
      echo_oe_o          <= 1'b0;
    end else begin
      case (echo_src(ir_r_ff))
        SRC_UPDATE: begin
          echo_clock_out_o   <= upd_echo_r_ff;
          echo_clock_out_n_o <= upd_echo_n_r_ff;
          echo_oe_o          <= 1'b1;
        end
        SRC_HIZ: begin
          echo_clock_out_o   <= 1'b0;
          echo_clock_out_n_o <= 1'b0;
          echo_oe_o          <= 1'b0;
        end
        default: begin
          echo_clock_out_o   <= core_echo_i;
          echo_clock_out_n_o <= core_echo_n_i;
          echo_oe_o          <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      dq_o    <= {DQ_W{1'b0}};
      dq_oe_o <= 1'b0;
    end else begin
      case (dq_src(ir_r_ff, ctrl_r_ff))
        SRC_UPDATE: begin
          dq_o    <= upd_dq_r_ff;
          dq_oe_o <= 1'b1;
        end
        SRC_HIZ: begin
          dq_o    <= {DQ_W{1'b0}};
          dq_oe_o <= 1'b0;
        end
        default: begin
          dq_o    <= core_dq_i;
          dq_oe_o <= core_dq_oe_i;
        end
      endcase
    end
  end

  // Ident and bypass have no defined capture; pad sampling is chosen for them.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cap_echo_pad_o <= 1'b1;
      cap_dq_pad_o   <= 1'b1;
    end else if (ir_r_ff == IR_SAMPLE) begin
      cap_echo_pad_o <= 1'b0;
      cap_dq_pad_o   <= ~mem_read_i;
    end else begin
      cap_echo_pad_o <= 1'b1;
      cap_dq_pad_o   <= 1'b1;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  extest_echo_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    ir_r_ff == IR_EXTEST |=> echo_oe_o && echo_clock_out_o == $past(upd_echo_r_ff))
    else $error("Echo pins not driven from update under extest.");

  extest_dq_off_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    ir_r_ff == IR_EXTEST && !ctrl_r_ff |=> !dq_oe_o)
    else $error("Data pins driven under extest with control bit low.");

  extest_dq_on_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    ir_r_ff == IR_EXTEST && ctrl_r_ff |=> dq_oe_o && dq_o == $past(upd_dq_r_ff))
    else $error("Data pins not driven from update with control bit high.");

  samplez_hiz_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    ir_r_ff == IR_SAMPLE_Z |=> !echo_oe_o && !dq_oe_o)
    else $error("Output pins driven under sample with tristate.");

  core_path_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (ir_r_ff == IR_IDCODE || ir_r_ff == IR_SAMPLE || ir_r_ff == IR_BYPASS)
    |=> dq_o == $past(core_dq_i) && dq_oe_o == $past(core_dq_oe_i) && echo_oe_o)
    else $error("Output pins not on core path.");

  pad_capture_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (ir_r_ff == IR_EXTEST || ir_r_ff == IR_SAMPLE_Z) |=> cap_echo_pad_o && cap_dq_pad_o)
    else $error("Pad capture not selected.");

  sample_capture_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    ir_r_ff == IR_SAMPLE |=> !cap_echo_pad_o && cap_dq_pad_o == !$past(mem_read_i))
    else $error("Sample capture selection wrong.");

  shadow_hold_a: assert property (@(posedge tck_i) disable iff (tlr_i)
    !update_ir_i |=> $stable(ir_ff))
    else $error("Instruction shadow changed outside Update-IR.");

  tlr_ident_a: assert property (@(posedge tck_i) disable iff (tlr_i)
    $fell(tlr_i) |-> ir_ff == IR_IDCODE)
    else $error("Identification not loaded by Test-Logic-Reset.");

  ctrl_load_a: assert property (@(posedge tck_i) disable iff (tlr_i)
    !(update_dr_i && (ir_ff == IR_EXTEST || ir_ff == IR_SAMPLE)) |=> $stable(ctrl_ff))
    else $error("Control bit loaded outside allowed Update-DR.");

  bypass_path_a: assert property (@(posedge tck_i) disable iff (tlr_i)
    shift_dr_i && ir_ff == IR_BYPASS ##1 shift_dr_i && ir_ff == IR_BYPASS |=> tdo_ff == $past(tdi_i, 2))
    else $error("Bypass path is not one bit long.");

  id_capture_a: assert property (@(posedge tck_i) disable iff (tlr_i)
    capture_dr_i && ir_ff == IR_IDCODE |=> id_ff == ID_VALUE)
    else $error("Identification value not captured.");

endmodule

// ===== tb/tap_ctrl_model.sv
// Behavioural test-port controller that drives the state decodes behind a gated test clock.
`timescale 1ns/10ps
module tap_ctrl_model #(
  parameter int unsigned DQ_W = 18
) (
  output logic            tck_o,
  output logic            tlr_o,
  output logic            tdi_o,
  output logic            capture_dr_o,
  output logic            shift_ir_o,
  output logic            update_ir_o,
  output logic            shift_dr_o,
  output logic            update_dr_o,
  output logic            bsr_so_o,
  output logic            ctrl_shift_o,
  output logic            upd_echo_o,
  output logic            upd_echo_n_o,
  output logic [DQ_W-1:0] upd_dq_o,
  input  wire logic       tdo_i
);
  logic        run;
  integer      pseed;
  logic [31:0] rnd;
  initial begin
    {run, tck_o, tlr_o, tdi_o, capture_dr_o, shift_ir_o, update_ir_o, shift_dr_o, update_dr_o} = '0;
    {bsr_so_o, ctrl_shift_o, upd_echo_o, upd_echo_n_o, upd_dq_o} = '0;
    pseed = 52;
  end
  // ==========================================================================
  // Test clock
  // ==========================================================================
  // The clock only runs inside frames and rests low otherwise.
  always #16 tck_o = run ? ~tck_o : 1'b0;
  // The chain output toggles every cycle so a stale value is never mistaken for data.
  always @(negedge tck_o) bsr_so_o <= ~bsr_so_o;
  // ==========================================================================
  // Frames
  // ==========================================================================
  task automatic tick();
    @(negedge tck_o);
  endtask
  task automatic frame_end();
    tick();
    run = 1'b0;
  endtask
  task automatic new_upd();
    rnd = $random(pseed);
    {upd_echo_o, upd_echo_n_o, upd_dq_o} = rnd[DQ_W+1:0];
  endtask
  task automatic reset_tap();
    run = 1'b1;
    tlr_o = 1'b1;
    tick();
    tick();
    tlr_o = 1'b0;
    frame_end();
  endtask
  // Codes 011, 101 and 110 are never sent by this controller.
  task automatic load_ir(input logic [2:0] code);
    run = 1'b1;
    for (int i = 0; i < 3; i++) begin
      tick();
      shift_ir_o = 1'b1;
      tdi_o = code[i];
    end
    tick();
    shift_ir_o = 1'b0;
    tdi_o = ~tdi_o;
    update_ir_o = 1'b1;
    new_upd();
    tick();
    update_ir_o = 1'b0;
    frame_end();
  endtask
  task automatic load_dr(input logic ctrl);
    run = 1'b1;
    tick();
    ctrl_shift_o = ctrl;
    update_dr_o = 1'b1;
    new_upd();
    tick();
    update_dr_o = 1'b0;
    frame_end();
  endtask
  task automatic scan_dr(input int n, input logic [63:0] din, output logic [63:0] dout);
    dout = '0;
    run = 1'b1;
    tick();
    capture_dr_o = 1'b1;
    tick();
    capture_dr_o = 1'b0;
    shift_dr_o = 1'b1;
    for (int i = 0; i < n; i++) begin
      tdi_o = din[i];
      tick();
      dout[i] = tdo_i;
    end
    shift_dr_o = 1'b0;
    tdi_o = ~tdi_o;
    frame_end();
  endtask
endmodule

// ===== tb/boundary_scan_instruction_ctrl_tb.sv
// Self-checking bench for the test-port instruction control against a behavioural pin model.
`timescale 1ns/10ps
module boundary_scan_instruction_ctrl_tb;
  import bscan_ctrl_pkg::*;
  localparam int unsigned W = DQ_W_DEF;
  // Identification value is arbitrary.
  localparam logic [ID_W-1:0] ID_TB = 32'h2468_ACE1;
  logic          clk, srst, tck, tlr, tdi, cap_dr, sh_ir, up_ir, sh_dr, up_dr, bso, cshift, ue, uen, tdo;
  logic [W-1:0]  udq, cdq, dq;
  logic [2:0]    instr, m_ir;
  logic          ibh, ibm, ibl, ce, cen, cdoe, mr, echo, echo_n, echo_oe, dq_oe, cap_e, cap_d, m_ctrl;
  logic [W+1:0]  m_upd;
  logic          tdo_oe, shift_q;
  logic [63:0]   din, dout;
  integer        seed = 52;
  int            fail_count = 0;
  int            tests_run = 0;

  boundary_scan_instruction_ctrl #(.DQ_W(W), .ID_VALUE(ID_TB)) boundary_scan_instruction_ctrl_i (
    .ref_clk_i(clk), .srst_i(srst), .tck_i(tck), .tlr_i(tlr), .tdi_i(tdi), .capture_dr_i(cap_dr),
    .shift_ir_i(sh_ir), .update_ir_i(up_ir), .shift_dr_i(sh_dr), .update_dr_i(up_dr), .bsr_so_i(bso),
    .ctrl_shift_i(cshift), .upd_echo_i(ue), .upd_echo_n_i(uen), .upd_dq_i(udq), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
    .instr_o(instr), .instr_bit_high_o(ibh), .instr_bit_mid_o(ibm), .instr_bit_low_o(ibl),
    .core_echo_i(ce), .core_echo_n_i(cen), .core_dq_i(cdq), .core_dq_oe_i(cdoe), .mem_read_i(mr),
    .echo_clock_out_o(echo), .echo_clock_out_n_o(echo_n), .echo_oe_o(echo_oe), .dq_o(dq), .dq_oe_o(dq_oe),
    .cap_echo_pad_o(cap_e), .cap_dq_pad_o(cap_d));
  tap_ctrl_model #(.DQ_W(W)) tap_ctrl_model_i (
    .tck_o(tck), .tlr_o(tlr), .tdi_o(tdi), .capture_dr_o(cap_dr), .shift_ir_o(sh_ir), .update_ir_o(up_ir),
    .shift_dr_o(sh_dr), .update_dr_o(up_dr), .bsr_so_o(bso), .ctrl_shift_o(cshift), .upd_echo_o(ue),
    .upd_echo_n_o(uen), .upd_dq_o(udq), .tdo_i(tdo));

  always #25 clk = ~clk;
  // The test data output enable follows the shift states one test clock late.
  always @(posedge tck) shift_q <= sh_ir || sh_dr;
  always @(negedge tck) if ($time > 0) check(64'(tdo_oe), 64'(shift_q));

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Eight reference cycles cover the minimum spacing between two updates.
  task automatic ir(input logic [2:0] code);
    tap_ctrl_model_i.load_ir(code);
    m_ir = code;
    m_upd = {ue, uen, udq};
    repeat (8) @(negedge clk);
    check(64'(instr), 64'(code));
    check(64'({ibh, ibm, ibl}), 64'(code));
  endtask
  task automatic dr(input logic b);
    tap_ctrl_model_i.load_dr(b);
    if (m_ir == IR_EXTEST || m_ir == IR_SAMPLE) m_ctrl = b;
    m_upd = {ue, uen, udq};
    repeat (8) @(negedge clk);
  endtask
  task automatic run_mem(input int n, input string name);
    logic [63:0] exp, msk;
    for (int k = 0; k < n; k++) begin
      {ce, cen, cdoe, mr} = 4'($random(seed));
      cdq = W'($random(seed));
      @(negedge clk);
      msk = '1;
      if (m_ir == IR_EXTEST) begin
        exp = 64'({m_upd[W+1], m_upd[W], 1'b1, m_ctrl, 2'b11, m_upd[W-1:0]});
        if (!m_ctrl) msk[W-1:0] = '0;
      end else if (m_ir == IR_SAMPLE_Z) begin
        exp = 64'({4'h0, 2'b11, W'(0)});
        msk = 64'hF << W;
      end else begin
        exp = 64'({ce, cen, 1'b1, cdoe, 1'b0, ~mr, cdq});
        // Capture source under identification and bypass has no defined value.
        if (m_ir != IR_SAMPLE) msk[W+1:W] = 2'b00;
      end
      check(64'({echo, echo_n, echo_oe, dq_oe, cap_e, cap_d, dq}) & msk, exp & msk);
    end
    $display("test %s done", name);
  endtask

  initial begin
    {clk, ce, cen, cdoe, mr} = '0;
    cdq = '0;
    srst = 1'b1;
    repeat (10) @(negedge clk);
    tap_ctrl_model_i.reset_tap();
    repeat (10) @(negedge clk);
    srst = 1'b0;
    {m_ir, m_ctrl, m_upd} = {IR_IDCODE, 1'b0, (W+2)'(0)};
    repeat (2) @(negedge clk);
    check(64'(instr), 64'(IR_IDCODE));
    run_mem(6, "reset");
    din = {$random(seed), $random(seed)};
    tap_ctrl_model_i.scan_dr(32, din, dout);
    check(dout[31:0], ID_TB);
    dr(1'b1);
    ir(IR_EXTEST);
    run_mem(6, "extest_ctrl0");
    dr(1'b1);
    run_mem(6, "extest_ctrl1");
    ir(IR_SAMPLE_Z);
    run_mem(6, "sample_z");
    ir(IR_SAMPLE);
    dr(1'b0);
    run_mem(8, "sample");
    ir(IR_EXTEST);
    run_mem(4, "extest_after_sample");
    ir(IR_BYPASS);
    run_mem(6, "bypass");
    din = {$random(seed), $random(seed)};
    tap_ctrl_model_i.scan_dr(16, din, dout);
    check(dout[15:1], din[14:0]);
    ir(IR_EXTEST);
    dr(1'b1);
    run_mem(2, "extest_before_reset");
    tap_ctrl_model_i.reset_tap();
    {m_ir, m_ctrl} = {IR_IDCODE, 1'b0};
    repeat (8) @(negedge clk);
    check(64'(instr), 64'(IR_IDCODE));
    run_mem(4, "second_reset");
    stop_test();
  end
  initial begin
    repeat (20000) @(negedge clk);
    fail_count++;
    stop_test();
  end
endmodule
